//--- shared/bus_flags_pkg.sv
// constants for the two-wire bus event status flag block
package bus_flags_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CONTROL    = 4'h0;
   localparam logic [3:0] OFF_STATUS     = 4'h4;
   localparam logic [3:0] OFF_EVENT      = 4'h8;
   localparam logic [3:0] OFF_EVENT_MASK = 4'hc;

   // ------------------------------------------------------------
   // bus_control_reg fields
   // ------------------------------------------------------------
   localparam int BIT_COMM_EXIT  = 6;
   localparam int BIT_UNIT_ENABLE = 7;

   // ------------------------------------------------------------
   // bus_status_reg, event and mask fields (same layout)
   // ------------------------------------------------------------
   localparam int BIT_STOP_SEEN  = 0;
   localparam int BIT_START_SEEN = 1;
   localparam int BIT_ACK_SEEN   = 2;
   localparam int FLAG_W         = 3;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0]        CONTROL_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RESET   = 3'h0;
   localparam logic [3:0]        BIT_FIRST     = 4'h1;
   localparam logic [3:0]        BIT_LAST      = 4'h9;
   localparam logic [3:0]        BIT_IDLE      = 4'h0;

endpackage

//--- design/bus_event_flags.sv
// two-wire bus event status flags with avalon-mm register slave
`timescale 1ns/1ns
`default_nettype none

module bus_event_flags
   import bus_flags_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   input  wire logic        serial_clock_line,
   input  wire logic        serial_data_line
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("SYNC_STAGES must be 2");
   end

   // ------------------------------------------------------------
   // line synchronisers and edge finding
   // ------------------------------------------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_prev;
   logic       sda_prev;
   logic [1:0] next_scl_sync;
   logic [1:0] next_sda_sync;
   logic       next_scl_prev;
   logic       next_sda_prev;
   logic       scl_now;
   logic       sda_now;
   logic       scl_rise;
   logic       start_cond;
   logic       stop_cond;

   always_comb
   begin
      next_scl_sync = {scl_sync[0], serial_clock_line};
      next_sda_sync = {sda_sync[0], serial_data_line};
      next_scl_prev = scl_sync[1];
      next_sda_prev = sda_sync[1];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_sync <= next_scl_sync;
         sda_sync <= next_sda_sync;
         scl_prev <= next_scl_prev;
         sda_prev <= next_sda_prev;
      end
   end

   assign scl_now    = scl_sync[1];
   assign sda_now    = sda_sync[1];
   assign scl_rise   = scl_now & ~scl_prev;
   assign start_cond = scl_now & scl_prev & sda_prev & ~sda_now;
   assign stop_cond  = scl_now & scl_prev & ~sda_prev & sda_now;

   // ------------------------------------------------------------
   // control register and bus access decode
   // ------------------------------------------------------------
   logic        unit_enable;
   logic        enable_prev;
   logic        resp;
   logic [31:0] rdata;
   logic        next_unit_enable;
   logic        next_resp;
   logic [31:0] next_rdata;
   logic        wr_take;
   logic        comm_exit_bit;
   logic        enable_fall;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] events;
   logic [FLAG_W-1:0] mask;

   // a write lands at the edge where waitrequest is seen low, never earlier
   assign wr_take         = avs_write & resp & avs_byteenable[0];
   assign avs_waitrequest = (avs_read | avs_write) & ~resp;
   assign avs_readdata    = rdata;
   assign comm_exit_bit   = wr_take & (avs_address == OFF_CONTROL)
                            & avs_writedata[BIT_COMM_EXIT];
   assign enable_fall     = enable_prev & ~unit_enable;

   always_comb
   begin
      next_resp        = (avs_read | avs_write) & ~resp;
      next_unit_enable = unit_enable;
      if (wr_take && avs_address == OFF_CONTROL)
      begin
         next_unit_enable = avs_writedata[BIT_UNIT_ENABLE];
      end
      next_rdata = rdata;
      if (avs_read && !resp)
      begin
         case (avs_address)
            OFF_CONTROL:    next_rdata = {24'h0, unit_enable, 7'h0};
            OFF_STATUS:     next_rdata = {29'h0, flags};
            OFF_EVENT:      next_rdata = {29'h0, events};
            OFF_EVENT_MASK: next_rdata = {29'h0, mask};
            default:        next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         unit_enable <= CONTROL_RESET[BIT_UNIT_ENABLE];
         enable_prev <= CONTROL_RESET[BIT_UNIT_ENABLE];
         resp        <= 1'b0;
         rdata       <= 32'h0;
      end
      else
      begin
         unit_enable <= next_unit_enable;
         enable_prev <= unit_enable;
         resp        <= next_resp;
         rdata       <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // clock counting and status flags
   // ------------------------------------------------------------
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [FLAG_W-1:0] next_flags;
   logic       first_clk;
   logic       ninth_clk;
   logic       flag_wipe;

   assign first_clk = unit_enable & scl_rise & ((bit_cnt == BIT_IDLE) | (bit_cnt == BIT_LAST));
   assign ninth_clk = unit_enable & scl_rise & (bit_cnt == BIT_LAST - 4'h1);
   assign flag_wipe = enable_fall | ~unit_enable;

   always_comb
   begin
      next_bit_cnt = bit_cnt;
      if (!unit_enable || start_cond || stop_cond)
      begin
         next_bit_cnt = BIT_IDLE;
      end
      else if (first_clk)
      begin
         next_bit_cnt = BIT_FIRST;
      end
      else if (scl_rise && bit_cnt != BIT_IDLE)
      begin
         next_bit_cnt = bit_cnt + 4'h1;
      end
      next_flags = flags;
      // ack: clears first, a set in the same cycle wins
      if (stop_cond || first_clk || comm_exit_bit || flag_wipe)
      begin
         next_flags[BIT_ACK_SEEN] = 1'b0;
      end
      if (ninth_clk && !sda_now)
      begin
         next_flags[BIT_ACK_SEEN] = 1'b1;
      end
      // start: cleared at the first clock of the byte after the address
      if (stop_cond || comm_exit_bit || flag_wipe
          || (first_clk && bit_cnt == BIT_LAST))
      begin
         next_flags[BIT_START_SEEN] = 1'b0;
      end
      if (unit_enable && start_cond)
      begin
         next_flags[BIT_START_SEEN] = 1'b1;
      end
      // stop: held until the address byte's first clock after a start
      if (flag_wipe || (first_clk && bit_cnt == BIT_IDLE))
      begin
         next_flags[BIT_STOP_SEEN] = 1'b0;
      end
      if (unit_enable && stop_cond)
      begin
         next_flags[BIT_STOP_SEEN] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         bit_cnt <= BIT_IDLE;
         flags   <= FLAGS_RESET;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         flags   <= next_flags;
      end
   end

   // ------------------------------------------------------------
   // interrupt events and mask
   // ------------------------------------------------------------
   logic [FLAG_W-1:0] next_events;
   logic [FLAG_W-1:0] next_mask;
   logic [FLAG_W-1:0] rises;

   assign rises = next_flags & ~flags;

   always_comb
   begin
      next_events = events;
      next_mask   = mask;
      if (wr_take && avs_address == OFF_EVENT)
      begin
         next_events = events & ~avs_writedata[FLAG_W-1:0];
      end
      if (wr_take && avs_address == OFF_EVENT_MASK)
      begin
         next_mask = avs_writedata[FLAG_W-1:0];
      end
      next_events = next_events | rises;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         events <= FLAGS_RESET;
         mask   <= FLAGS_RESET;
         irq    <= 1'b0;
      end
      else
      begin
         events <= next_events;
         mask   <= next_mask;
         irq    <= |(next_events & next_mask);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_ack_on_ninth: assert property (ninth_clk && !sda_now |=> flags[BIT_ACK_SEEN])
      else $error("ack flag not set after ninth clock with data low");
   a_ack_clear: assert property (
      (stop_cond || first_clk || comm_exit_bit) && !(ninth_clk && !sda_now)
      |=> !flags[BIT_ACK_SEEN])
      else $error("ack flag not cleared");
   a_ack_cause: assert property ($rose(flags[BIT_ACK_SEEN])
      |-> $past(ninth_clk) && !$past(sda_now))
      else $error("ack flag rose without ninth clock");
   a_start_set: assert property (unit_enable && start_cond
      |=> flags[BIT_START_SEEN] && bit_cnt == BIT_IDLE)
      else $error("start flag not set on start");
   a_start_clear: assert property (
      first_clk && bit_cnt == BIT_LAST && !start_cond |=> !flags[BIT_START_SEEN])
      else $error("start flag not cleared after address byte");
   a_stop_set: assert property (unit_enable && stop_cond
      |=> flags[BIT_STOP_SEEN] && !flags[BIT_START_SEEN] && !flags[BIT_ACK_SEEN])
      else $error("stop condition did not update flags");
   a_stop_hold: assert property ($fell(flags[BIT_STOP_SEEN])
      |-> $past(flag_wipe) || ($past(first_clk) && $past(bit_cnt) == BIT_IDLE))
      else $error("stop flag dropped early");
   a_disable_wipe: assert property (enable_fall |=> flags == FLAGS_RESET)
      else $error("flags survive disable");
   a_sync_delay: assert property (
      unit_enable && $fell(serial_data_line) && serial_clock_line
      && $past(serial_clock_line) |-> ##2 start_cond)
      else $error("start seen at wrong delay");
   a_irq_level: assert property (|(events & mask) |-> irq)
      else $error("irq low with unmasked event");

   c_ack: cover property (ninth_clk && !sda_now);
   c_second_byte: cover property (first_clk && bit_cnt == BIT_LAST && flags[BIT_START_SEEN]);
   c_stop: cover property (stop_cond && unit_enable ##1 flags[BIT_STOP_SEEN]);
   c_irq: cover property ($rose(irq));

endmodule

`default_nettype wire

//--- sim/bus_master_model.sv
// two-wire bus master model driving the clock and data lines
`timescale 1ns/1ns
`default_nettype none

module bus_master_model
(
   input  wire logic clk_sys,
   output logic      scl,
   output logic      sda
);
   // released lines sit at their pull-up level
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // data moves only while clock is low, so no false start or stop
   task automatic send_bit(input logic b);
      scl <= 1'b0;
      hold(2);
      sda <= b;
      hold(2);
      scl <= 1'b1;
      hold(4);
   endtask

   task automatic start_cond();
      if (!(scl && sda))
      begin
         scl <= 1'b0;
         hold(2);
         sda <= 1'b1;
         hold(2);
         scl <= 1'b1;
         hold(4);
      end
      sda <= 1'b0;
      hold(4);
   endtask

   task automatic stop_cond();
      scl <= 1'b0;
      hold(2);
      sda <= 1'b0;
      hold(2);
      scl <= 1'b1;
      hold(4);
      sda <= 1'b1;
      hold(4);
   endtask
endmodule

`default_nettype wire

//--- sim/test_bus_event_flags.sv
// self-checking bench for the bus event status flags
`timescale 1ns/1ns
`default_nettype none

module test_bus_event_flags;
   import bus_flags_pkg::*;
   logic        clk_sys;
   logic        resetn;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        scl;
   logic        sda;
   logic [31:0] rdat;
   int          fails;
   int          tests_run;

   bus_event_flags u_bus_event_flags (.clk_sys(clk_sys), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .serial_clock_line(scl), .serial_data_line(sda));
   bus_master_model u_bus_master_model (.clk_sys(clk_sys), .scl(scl), .sda(sda));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e);
      tests_run++;
      if (rdat !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, rdat);
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      acc(1'b0, a, 32'h00000000);
      chk(n, {24'h0, e});
   endtask

   // irq is looked at mid-cycle, where it has settled
   task automatic irq_is(input logic e, input string n);
      @(negedge clk_sys);
      rdat = {31'h0, irq};
      chk(n, {31'h0, e});
      @(posedge clk_sys);
   endtask

   task automatic byte_out(input logic ack);
      repeat (8) u_bus_master_model.send_bit(1'b1);
      u_bus_master_model.send_bit(ack);
   endtask

   task automatic t_reset();
      rd(OFF_CONTROL, 8'h00, "control");
      rd(OFF_STATUS, 8'h00, "status");
      rd(OFF_EVENT, 8'h00, "event");
      rd(OFF_EVENT_MASK, 8'h00, "mask");
      rd(4'h2, 8'h00, "unmapped");
   endtask

   task automatic t_ack_start();
      acc(1'b1, OFF_CONTROL, 32'ha5a5a580);
      u_bus_master_model.start_cond();
      rd(OFF_STATUS, 8'h02, "start");
      byte_out(1'b0);
      rd(OFF_STATUS, 8'h06, "ack");
      u_bus_master_model.send_bit(1'b1);
      rd(OFF_STATUS, 8'h00, "next byte");
      repeat (7) u_bus_master_model.send_bit(1'b0);
      u_bus_master_model.send_bit(1'b1);
      rd(OFF_STATUS, 8'h00, "nack");
      u_bus_master_model.stop_cond();
      rd(OFF_STATUS, 8'h01, "stop");
   endtask

   task automatic t_stop_exit();
      u_bus_master_model.start_cond();
      rd(OFF_STATUS, 8'h03, "stop held");
      u_bus_master_model.send_bit(1'b1);
      rd(OFF_STATUS, 8'h02, "address clk");
      repeat (7) u_bus_master_model.send_bit(1'b1);
      u_bus_master_model.send_bit(1'b0);
      rd(OFF_STATUS, 8'h06, "ack again");
      acc(1'b1, OFF_CONTROL, 32'h000000c0);
      rd(OFF_STATUS, 8'h00, "exit");
      rd(OFF_CONTROL, 8'h80, "exit pulse");
   endtask

   task automatic t_disable();
      u_bus_master_model.stop_cond();
      avs_byteenable <= 4'he;
      acc(1'b1, OFF_CONTROL, 32'h00000000);
      avs_byteenable <= 4'hf;
      rd(OFF_STATUS, 8'h01, "masked write");
      acc(1'b1, OFF_CONTROL, 32'hffffff00);
      rd(OFF_STATUS, 8'h00, "disable");
      u_bus_master_model.start_cond();
      rd(OFF_STATUS, 8'h00, "disabled start");
      acc(1'b1, OFF_CONTROL, 32'h00000080);
      u_bus_master_model.stop_cond();
      rd(OFF_STATUS, 8'h01, "stop again");
   endtask

   task automatic t_irq();
      acc(1'b1, OFF_EVENT, 32'h00000007);
      rd(OFF_EVENT, 8'h00, "event clear");
      acc(1'b1, OFF_EVENT_MASK, 32'h00000001);
      u_bus_master_model.start_cond();
      irq_is(1'b0, "irq masked");
      u_bus_master_model.stop_cond();
      rd(OFF_EVENT, 8'h03, "events");
      irq_is(1'b1, "irq");
      acc(1'b1, OFF_EVENT, 32'h00000001);
      rd(OFF_EVENT, 8'h02, "event w1c");
      irq_is(1'b0, "irq clear");
   endtask

   // reset in mid-run with flags, events, mask and irq all standing
   task automatic t_mid_reset();
      acc(1'b1, OFF_EVENT_MASK, 32'h00000002);
      irq_is(1'b1, "irq before reset");
      resetn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(OFF_STATUS, 8'h00, "reset status");
      rd(OFF_CONTROL, 8'h00, "reset control");
      rd(OFF_EVENT, 8'h00, "reset event");
      rd(OFF_EVENT_MASK, 8'h00, "reset mask");
      irq_is(1'b0, "reset irq");
   endtask

   initial
   begin
      #100000;
      fails++;
      finish_test();
   end

   initial
   begin
      fails = 0;
      tests_run = 0;
      resetn = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_ack_start();
      t_stop_exit();
      t_disable();
      t_irq();
      t_mid_reset();
      finish_test();
   end
endmodule

`default_nettype wire
